//--- hw/spc_top.sv
// Strobe pulse controller top: APB register, strobe state machine, checks
`timescale 1ns/1ps
//
// Behaviour
// (RULE1) Status bit 15 reads the present level of the strobe pin.
// (RULE2) Status bit 14 shows the strobe is asserted for the current frame.
// (RULE3) Counted-pulse mode drives strobe in vertical blanking for programmed length.
// (RULE4) Software keeps integration one frame and pulse shorter than blanking.
// (RULE5) Strobe postponed by the two-bit frame delay count.
// (RULE6) Trigger point 1 starts after reset phase; 0 after readout.
// (RULE7) Repeat bit 1 strobes every frame; 0 strobes one frame only.
// (RULE8) Frame-span mode raises strobe before frame reset until readout end.
// (RULE9) Pulse length is the eight-bit field times 1024 pixel clocks.
// (RULE10) Length 0xff ends the pulse just before first row readout.
// (RULE11) Reset: length 8, trigger point and repeat 1, both enables 0.
// (RULE12) Mode enables apply at next frame start; other fields apply at once.
// (RULE13) One-shot mode strobes once, then waits for an enable rewrite.
// (RULE14) Strobe is a registered flop, low when both modes are off.
module spc_top
   import spc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        frame_start,
   input  wire logic        reset_end,
   input  wire logic        row_start,
   input  wire logic        readout_end,
   output logic             strobe
);
   import spc_pkg::*;

   spc_cfg_if cfg ();

   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;
   logic             strobe_q;
   logic             pulse_en_q;
   logic             span_en_q;
   logic [1:0]       dly_q;
   logic             tps_q;
   logic             every_q;
   logic [7:0]       len_q;
   logic             rearm_q;
   spc_state_t       state_q;
   spc_state_t       state_d;
   logic             tmr_start;
   logic             trig_evt;
   logic             len_max;
   logic             acc;
   logic             hit_ctrl;
   logic             wr_commit;
   logic [15:0]      ctrl_rd;

   spc_frame_seq u_seq
   (
      .clk   (pclk),
      .rst_n (presetn),
      .cfg   (cfg.seq)
   );

   spc_pulse_timer u_tmr
   (
      .clk   (pclk),
      .rst_n (presetn),
      .cfg   (cfg.tmr)
   );

   assign cfg.frame_start = frame_start;
   assign cfg.ce          = ce;
   assign cfg.pulse_en_sh = pulse_en_q;
   assign cfg.span_en_sh  = span_en_q;
   assign cfg.rearm       = rearm_q;
   assign cfg.frame_dly   = dly_q;
   assign cfg.every       = every_q;
   assign cfg.len         = len_q;
   assign cfg.tmr_start   = tmr_start;
   assign cfg.tmr_stop    = (state_q == ST_PULSE) && (state_d != ST_PULSE);

   // APB decode
   assign acc       = psel && penable;
   assign hit_ctrl  = (paddr == STROBE_CTRL_ADDR);
   assign wr_commit = acc && pready_q && pwrite && hit_ctrl;

   // Readback image of strobe_control
   always_comb
   begin
      ctrl_rd                   = 16'h0000;
      ctrl_rd[PIN_BIT]          = strobe_q; // RULE1
      ctrl_rd[HIT_BIT]          = cfg.hit; // RULE2
      ctrl_rd[PULSE_EN_BIT]     = pulse_en_q;
      ctrl_rd[DLY_HI:DLY_LO]    = dly_q;
      ctrl_rd[TPS_BIT]          = tps_q;
      ctrl_rd[EVERY_BIT]        = every_q;
      ctrl_rd[SPAN_EN_BIT]      = span_en_q;
      ctrl_rd[LEN_HI:LEN_LO]    = len_q;
   end

   // One wait cycle, then answer; unmapped address gives pslverr
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (acc && !pready_q)
         begin
            pready_q  <= 1'b1;
            pslverr_q <= !hit_ctrl;
            if (!pwrite && hit_ctrl)
               prdata_q <= {16'h0000, ctrl_rd};
            else
               prdata_q <= 32'h0000_0000;
         end
         else
         begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
         end
      end
   end

   // Control fields; low byte lane holds length, high lane the options
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         len_q      <= LEN_RST; // RULE11
         tps_q      <= TPS_RST; // RULE11
         every_q    <= EVERY_RST; // RULE11
         dly_q      <= DLY_RST;
         pulse_en_q <= 1'b0; // RULE11
         span_en_q  <= 1'b0; // RULE11
         rearm_q    <= 1'b0;
      end
      else if (ce)
      begin
         rearm_q <= 1'b0;
         if (wr_commit && pstrb[0])
            len_q <= pwdata[LEN_HI:LEN_LO];
         if (wr_commit && pstrb[1])
         begin
            pulse_en_q <= pwdata[PULSE_EN_BIT];
            dly_q      <= pwdata[DLY_HI:DLY_LO];
            tps_q      <= pwdata[TPS_BIT];
            every_q    <= pwdata[EVERY_BIT];
            span_en_q  <= pwdata[SPAN_EN_BIT];
            rearm_q    <= pwdata[PULSE_EN_BIT] | pwdata[SPAN_EN_BIT]; // RULE13
         end
      end
   end

   // Trigger point of the counted pulse
   assign trig_evt = tps_q ? reset_end : readout_end; // RULE6
   assign len_max  = (len_q == LEN_MAX);

   always_comb
   begin
      state_d   = state_q;
      tmr_start = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (cfg.hit_new && cfg.span_act)
               state_d = ST_SPAN; // RULE8
            else if (cfg.hit_new && cfg.pulse_act && len_q != 8'h00)
               state_d = ST_ARMED; // RULE3
         end
         ST_SPAN:
         begin
            if (readout_end)
               state_d = ST_IDLE; // RULE8
         end
         ST_ARMED:
         begin
            if (trig_evt)
            begin
               state_d   = ST_PULSE; // RULE6
               tmr_start = 1'b1;
            end
         end
         ST_PULSE:
         begin
            if (len_max ? row_start : cfg.tmr_last)
               state_d = ST_IDLE; // RULE9 RULE10
         end
         default:
            state_d = ST_IDLE;
      endcase
      // Both modes off forces the pin low
      if (!cfg.pulse_act && !cfg.span_act)
         state_d = ST_IDLE; // RULE14
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_q <= ST_IDLE;
      else if (ce)
         state_q <= state_d;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         strobe_q <= 1'b0;
      else if (ce)
         strobe_q <= (state_d == ST_SPAN) || (state_d == ST_PULSE); // RULE14 RULE3
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign strobe  = strobe_q;

   // Helper: cycles spent in the pulse and length at its start
   logic [CNT_W-1:0] run_q;
   logic [7:0]       len_start_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_q       <= '0;
         len_start_q <= 8'h00;
      end
      else if (ce)
      begin
         if (state_q == ST_PULSE)
            run_q <= run_q + 1'b1;
         else
            run_q <= '0;
         if (tmr_start)
            len_start_q <= len_q;
      end
   end

   a_status_pin_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      ce && acc && !pready_q && !pwrite && hit_ctrl |=> prdata_q[PIN_BIT] == $past(strobe_q))
      else $error("status pin bit differs from strobe");

   a_status_hit_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      ce && acc && !pready_q && !pwrite && hit_ctrl |=> prdata_q[HIT_BIT] == $past(cfg.hit))
      else $error("triggered bit differs from frame hit");

   a_pulse_trigger_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      ce && state_q == ST_ARMED && trig_evt && (cfg.pulse_act || cfg.span_act) |=> strobe_q)
      else $error("pulse did not start at trigger point");

   a_pulse_exact_len: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      ce && state_q == ST_PULSE && cfg.tmr_last && !len_max && (cfg.pulse_act || cfg.span_act)
      |-> CNT_W'(run_q + 1'b1) == {len_start_q, {UNIT_SHIFT{1'b0}}})
      else $error("pulse length not length times 1024");

   a_span_hold_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      ce && state_q == ST_SPAN && !readout_end && cfg.span_act |=> strobe_q)
      else $error("frame span strobe dropped early");

   a_span_end_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      ce && state_q == ST_SPAN && readout_end |=> !strobe_q)
      else $error("frame span strobe not released at readout end");

   a_off_drives_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      ce && !cfg.pulse_act && !cfg.span_act |=> !strobe_q)
      else $error("strobe high with both modes off");

   a_enable_frame_sync: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
      !(ce && frame_start) |=> $stable(cfg.pulse_act) && $stable(cfg.span_act))
      else $error("mode enable changed outside frame start");

   a_max_len_truncate: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      ce && state_q == ST_PULSE && len_max && row_start |=> !strobe_q)
      else $error("maximum pulse not ended at first row");

   a_one_shot_once: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      ce && cfg.hit_new && !$past(every_q) && !$past(rearm_q) |-> !u_seq.armed_q)
      else $error("one-shot mode left armed after its strobe");

   // Strobe state machine checks
   a_zero_len_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      ce && state_q == ST_IDLE && cfg.hit_new && !cfg.span_act && len_q == 8'h00 |=> !strobe_q)
      else $error("zero length pulse drove strobe");

   a_armed_waits: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      ce && state_q == ST_ARMED && !trig_evt |=> !strobe_q)
      else $error("pulse started before trigger point");

   a_idle_stays_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      ce && state_q == ST_IDLE && !cfg.hit_new |=> !strobe_q)
      else $error("strobe rose without a selected frame");

   a_span_start_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      ce && state_q == ST_IDLE && cfg.hit_new && cfg.span_act |=> strobe_q)
      else $error("frame span strobe did not rise");

   a_pulse_holds_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      ce && state_q == ST_PULSE && !len_max && !cfg.tmr_last && cfg.pulse_act |=> strobe_q)
      else $error("counted pulse dropped before its count");

   // Register bus checks
   a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
      ce && acc && !pready_q |=> pready_q)
      else $error("ready not given after one wait cycle");

   a_pready_single: assert property (@(posedge pclk) disable iff (!presetn)
      ce && pready_q |=> !pready_q)
      else $error("ready held longer than one cycle");

   a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
      ce && acc && !pready_q && !hit_ctrl |=> pslverr_q && prdata_q == 32'h0000_0000)
      else $error("unmapped access not answered with error");

   a_len_write_now: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
      ce && wr_commit && pstrb[0] |=> len_q == $past(pwdata[LEN_HI:LEN_LO]))
      else $error("length write did not apply at once");

   c_span_frame: cover property (@(posedge pclk) disable iff (!presetn)
      state_q == ST_SPAN ##1 state_q == ST_IDLE);

   c_pulse_done: cover property (@(posedge pclk) disable iff (!presetn)
      state_q == ST_PULSE && cfg.tmr_last);

   c_max_truncate: cover property (@(posedge pclk) disable iff (!presetn)
      state_q == ST_PULSE && len_max && row_start);

   c_unmapped_err: cover property (@(posedge pclk) disable iff (!presetn)
      pready_q && pslverr_q);

   c_one_shot: cover property (@(posedge pclk) disable iff (!presetn)
      cfg.hit_new && !every_q);

endmodule // spc_top

//--- include/spc_pkg.sv
// Constants and types for the strobe pulse controller
package spc_pkg;
   // Register index and its APB byte address (index times four)
   localparam logic [7:0]  STROBE_CTRL_IDX  = 8'h23;
   localparam logic [7:0]  STROBE_CTRL_ADDR = {STROBE_CTRL_IDX[5:0], 2'b00};
   // Field positions of strobe_control
   localparam int          PIN_BIT          = 15;
   localparam int          HIT_BIT          = 14;
   localparam int          PULSE_EN_BIT     = 13;
   localparam int          DLY_HI           = 12;
   localparam int          DLY_LO           = 11;
   localparam int          TPS_BIT          = 10;
   localparam int          EVERY_BIT        = 9;
   localparam int          SPAN_EN_BIT      = 8;
   localparam int          LEN_HI           = 7;
   localparam int          LEN_LO           = 0;
   // Reset values
   localparam logic [7:0]  LEN_RST          = 8'h08;
   localparam logic        TPS_RST          = 1'b1;
   localparam logic        EVERY_RST        = 1'b1;
   localparam logic [1:0]  DLY_RST          = 2'h0;
   // Pulse length unit: 1024 pixel clocks
   localparam int          UNIT_CYC         = 1024;
   localparam int          UNIT_SHIFT       = $clog2(UNIT_CYC);
   localparam int          CNT_W            = 8 + UNIT_SHIFT;
   localparam logic [7:0]  LEN_MAX          = 8'hff;

   typedef enum logic [1:0] {ST_IDLE, ST_SPAN, ST_ARMED, ST_PULSE} spc_state_t;
endpackage

//--- include/spc_cfg_if.sv
// Bundle between the strobe controller core, frame sequencer and pulse timer
`timescale 1ns/1ps
interface spc_cfg_if;
   logic       frame_start;
   logic       ce;
   logic       pulse_en_sh;
   logic       span_en_sh;
   logic       rearm;
   logic [1:0] frame_dly;
   logic       every;
   logic       pulse_act;
   logic       span_act;
   logic       hit;
   logic       hit_new;
   logic       tmr_start;
   logic       tmr_stop;
   logic [7:0] len;
   logic       tmr_last;
   modport core (output frame_start, ce, pulse_en_sh, span_en_sh, rearm, frame_dly, every,
                 tmr_start, tmr_stop, len, input pulse_act, span_act, hit, hit_new, tmr_last);
   modport seq  (input frame_start, ce, pulse_en_sh, span_en_sh, rearm, frame_dly, every,
                 output pulse_act, span_act, hit, hit_new);
   modport tmr  (input ce, tmr_start, tmr_stop, len, output tmr_last);
endinterface // spc_cfg_if

//--- hw/spc_pulse_timer.sv
// Counted pulse timer in units of 1024 pixel clocks
`timescale 1ns/1ps
module spc_pulse_timer
   import spc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   spc_cfg_if.tmr    cfg
);
   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (cfg.ce)
      begin
         if (cfg.tmr_start)
            cnt_q <= {cfg.len, {UNIT_SHIFT{1'b0}}}; // RULE9
         else if (cfg.tmr_stop)
            cnt_q <= '0;
         else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   assign cfg.tmr_last = (cnt_q == CNT_W'(1));
endmodule // spc_pulse_timer

//--- hw/spc_frame_seq.sv
// Frame sequencer: frame-synchronised mode enables, frame delay, one-shot arming
`timescale 1ns/1ps
module spc_frame_seq
   import spc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   spc_cfg_if.seq    cfg
);
   logic       armed_q;
   logic [1:0] dly_q;
   logic       pulse_act_q;
   logic       span_act_q;
   logic       hit_q;
   logic       hit_new_q;
   logic       any_en;

   assign any_en = cfg.pulse_en_sh | cfg.span_en_sh;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         armed_q     <= 1'b0;
         dly_q       <= DLY_RST;
         pulse_act_q <= 1'b0;
         span_act_q  <= 1'b0;
         hit_q       <= 1'b0;
         hit_new_q   <= 1'b0;
      end
      else if (cfg.ce)
      begin
         hit_new_q <= 1'b0;
         if (cfg.frame_start)
         begin
            pulse_act_q <= cfg.pulse_en_sh; // RULE12
            span_act_q  <= cfg.span_en_sh; // RULE12
            hit_q       <= 1'b0;
            if (any_en && armed_q)
            begin
               if (dly_q == 2'h0)
               begin
                  hit_q     <= 1'b1;
                  hit_new_q <= 1'b1;
                  armed_q   <= cfg.every; // RULE7 RULE13
               end
               else
                  dly_q <= dly_q - 2'h1; // RULE5
            end
         end
         // Re-arm wins over the one-shot clear
         if (cfg.rearm)
         begin
            armed_q <= 1'b1; // RULE13
            dly_q   <= cfg.frame_dly; // RULE5
         end
      end
   end

   assign cfg.pulse_act = pulse_act_q;
   assign cfg.span_act  = span_act_q;
   assign cfg.hit       = hit_q;
   assign cfg.hit_new   = hit_new_q;
endmodule // spc_frame_seq

//--- verif/spc_lamp_model.sv
// Lamp driver model: measures strobe pulses
`timescale 1ns/1ps
module spc_lamp_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        strobe,
   input  wire logic [31:0] cyc,
   output int               n_pulses,
   output int               last_width,
   output int               rise_cyc
);
   int w;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         n_pulses <= 0;
         last_width <= 0;
         rise_cyc <= 0;
         w <= 0;
      end
      else if (strobe === 1'b1)
      begin
         if (w == 0)
            rise_cyc <= cyc;
         w <= w + 1;
      end
      else if (w != 0)
      begin
         last_width <= w;
         n_pulses <= n_pulses + 1;
         w <= 0;
      end
   end
endmodule // spc_lamp_model

//--- verif/tb_strobe_pulse_control.sv
// Testbench for the strobe pulse controller
`timescale 1ns/1ps
module tb_strobe_pulse_control;
   import spc_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  fr;
   logic        strobe;
   int          cyc;
   int          n_errors;
   int          total_checks;
   int          t[4];
   int          np;
   int          n_pulses;
   int          last_width;
   int          rise_cyc;
   localparam logic [7:0] A = STROBE_CTRL_ADDR;

   spc_top spc_top_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_start(fr[0]),
      .reset_end(fr[1]), .row_start(fr[2]), .readout_end(fr[3]), .strobe(strobe));
   spc_lamp_model spc_lamp_model_inst (.pclk(pclk), .presetn(presetn), .strobe(strobe),
      .cyc(cyc), .n_pulses(n_pulses), .last_width(last_width), .rise_cyc(rise_cyc));

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task print_verdict();
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask

   // One APB transfer; waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40)
         chk("pready", 32'h1, 32'h0);
   endtask

   task wr(input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, A, d, r, e);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk("prdata", x & m, r & m);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask

   task idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Pulse one frame event; stamp the edge that samples it
   task ev(input int k);
      @(posedge pclk);
      fr <= 4'(1 << k);
      @(posedge pclk);
      t[k] = cyc;
      fr <= 4'h0;
   endtask

   task frame(input int g);
      ev(0);
      idle(3);
      ev(1);
      idle(g);
      ev(2);
      idle(20);
      ev(3);
      idle(1200);
   endtask

   task frames(input int n, input int g);
      repeat (n) frame(g);
   endtask

   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      fr = 4'h0;
      cyc = 0;
      n_errors = 0;
      total_checks = 0;
      idle(5);
      presetn <= 1'b1;
      rd(A, 32'h0000_0608, 32'hffff_ffff, 1'b0);
      rd(8'h00, 32'h0, 32'hffff_ffff, 1'b1);
      pstrb <= 4'h1;
      wr(32'h0000_ff20);
      pstrb <= 4'hf;
      rd(A, 32'h0000_0620, 32'hffff_ffff, 1'b0);
      // Span mode; read-only bits written as ones
      wr(32'h0000_c708);
      idle(50);
      chk("strobe", 32'h0, {31'h0, strobe});
      ev(0);
      idle(3);
      ev(1);
      rd(A, 32'h0000_c708, 32'hffff_ffff, 1'b0);
      idle(40);
      ev(2);
      idle(20);
      ev(3);
      idle(5);
      chk("span rise", 32'(t[0] + 2), 32'(rise_cyc));
      chk("span width", 32'(t[3] - t[0] - 1), 32'(last_width));
      rd(A, 32'h0, 32'h0000_8000, 1'b0);
      np = n_pulses;
      wr(32'h0000_0608);
      frame(100);
      chk("off pulses", 32'(np), 32'(n_pulses));
      wr(32'h0000_2601);
      frame(1100);
      chk("reset rise", 32'(t[1] + 1), 32'(rise_cyc));
      chk("width", 32'(UNIT_CYC), 32'(last_width));
      wr(32'h0000_2201);
      frame(100);
      chk("readout rise", 32'(t[3] + 1), 32'(rise_cyc));
      chk("width", 32'(UNIT_CYC), 32'(last_width));
      wr(32'h0000_26ff);
      frame(300);
      chk("max width", 32'(t[2] - t[1]), 32'(last_width));
      np = n_pulses;
      wr(32'h0000_2001);
      frames(3, 100);
      chk("one shot", 32'(np + 1), 32'(n_pulses));
      wr(32'h0000_2001);
      frame(100);
      chk("rearm", 32'(np + 2), 32'(n_pulses));
      np = n_pulses;
      wr(32'h0000_3601);
      frames(2, 100);
      chk("delayed", 32'(np), 32'(n_pulses));
      frames(2, 100);
      chk("after delay", 32'(np + 2), 32'(n_pulses));
      print_verdict();
   end
endmodule // tb_strobe_pulse_control
